// ===== pkg/rbms_pkg.sv
// Constants and types for the reset and boot clock mode select block
package rbms_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned RST_IN_MIN_CYC  = 8;
    localparam int unsigned RST_OUT_CYC     = 1024;
    localparam int unsigned CNT_W           = 11;
    localparam logic [1:0]  SEL_BYP_EXT     = 2'h0;
    localparam logic [1:0]  SEL_BYP_CRYSTAL = 2'h1;
    localparam logic [1:0]  SEL_PLL_EXT     = 2'h2;
    localparam logic [1:0]  SEL_PLL_CRYSTAL = 2'h3;
    localparam logic [2:0]  PREDIV_RESET    = 3'h0;
    localparam int unsigned PLL_REF_MIN_HZ  = 2_000_000;
    localparam int unsigned PLL_REF_MAX_HZ  = 10_000_000;
    localparam logic [2:0]  SYNC_RESET      = 3'h7;

    typedef enum logic [1:0] {
        RBMS_SRC_EXT     = 2'h0,
        RBMS_SRC_OSC     = 2'h1,
        RBMS_SRC_CRYSTAL = 2'h2
    } rbms_src_t;

    typedef enum logic [2:0] {
        RBMS_ST_RESET   = 3'b001,
        RBMS_ST_STRETCH = 3'b010,
        RBMS_ST_RUN     = 3'b100
    } rbms_state_t;
endpackage

// ===== core/rbms_top.sv
// Reset qualification, reset stretch, boot clock mode decode and flash programming entry
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module rbms_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              reset_in_n,
    input  wire logic [1:0]        clock_boot_select,
    input  wire logic              crystal_drive_pin_in,
    output logic                   crystal_drive_pin_out,
    output logic                   crystal_drive_pin_oe,
    input  wire logic              flash_program_request_n,
    input  wire logic              test_mode,
    output logic                   system_clock_out,
    output logic                   reset_out_n,
    output logic                   core_reset_n,
    output logic                   pll_enable,
    output rbms_pkg::rbms_src_t    clock_source,
    output logic [2:0]             pll_prediv_field,
    output logic                   boot_mode_reserved,
    output logic                   flash_program_mode,
    output logic                   serial_port_flash_grant,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    import rbms_pkg::*;

    localparam logic [11:0] ADDR_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_PREDIV  = 12'h004;

    // Three-stage synchroniser on the pins; stages 2 and 3 must agree
    logic [2:0] rst_sync;
    logic       rst_q;
    logic [2:0] next_rst_sync;
    logic       next_rst_q;

    always_comb begin
        next_rst_sync = {rst_sync[1:0], reset_in_n};
        next_rst_q    = rst_q;
        if (rst_sync[2] == rst_sync[1]) begin
            next_rst_q = rst_sync[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync <= SYNC_RESET;
            rst_q    <= 1'b1;
        end else begin
            rst_sync <= next_rst_sync;
            rst_q    <= next_rst_q;
        end
    end

    // Mode straps pass the same synchroniser shape
    logic [1:0] sel_s1, sel_s2, sel_s3, sel_q;
    logic       cry_s1, cry_s2, cry_s3, cry_q;
    logic       req_s1, req_s2, req_s3, req_q;
    logic       tst_s1, tst_s2, tst_s3, tst_q;
    logic [1:0] next_sel_q;
    logic       next_cry_q, next_req_q, next_tst_q;

    always_comb begin
        next_sel_q  = (sel_s2 == sel_s3) ? sel_s3 : sel_q;
        next_cry_q  = (cry_s2 == cry_s3) ? cry_s3 : cry_q;
        next_req_q  = (req_s2 == req_s3) ? req_s3 : req_q;
        next_tst_q  = (tst_s2 == tst_s3) ? tst_s3 : tst_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_s1  <= 2'h0;
            sel_s2  <= 2'h0;
            sel_s3  <= 2'h0;
            sel_q   <= 2'h0;
            cry_s1  <= 1'b0;
            cry_s2  <= 1'b0;
            cry_s3  <= 1'b0;
            cry_q   <= 1'b0;
            req_s1  <= 1'b1;
            req_s2  <= 1'b1;
            req_s3  <= 1'b1;
            req_q   <= 1'b1;
            tst_s1  <= 1'b0;
            tst_s2  <= 1'b0;
            tst_s3  <= 1'b0;
            tst_q   <= 1'b0;
        end else begin
            sel_s1  <= clock_boot_select;
            sel_s2  <= sel_s1;
            sel_s3  <= sel_s2;
            sel_q   <= next_sel_q;
            cry_s1  <= crystal_drive_pin_in;
            cry_s2  <= cry_s1;
            cry_s3  <= cry_s2;
            cry_q   <= next_cry_q;
            req_s1  <= flash_program_request_n;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
            req_q   <= next_req_q;
            tst_s1  <= test_mode;
            tst_s2  <= tst_s1;
            tst_s3  <= tst_s2;
            tst_q   <= next_tst_q;
        end
    end

    // Low-time qualifier: glitches shorter than the minimum never reset the core
    logic [3:0]  low_cnt;
    logic [3:0]  next_low_cnt;
    logic        qual_rst;
    logic        next_qual_rst;
    rbms_state_t state;
    rbms_state_t next_state;
    logic [CNT_W-1:0] str_cnt;
    logic [CNT_W-1:0] next_str_cnt;
    logic        str_cnt_done;

    always_comb begin
        next_low_cnt  = low_cnt;
        next_qual_rst = qual_rst;
        if (rst_q) begin
            next_low_cnt  = 4'h0;
            next_qual_rst = 1'b0;
        end else if (low_cnt < 4'(RST_IN_MIN_CYC - 1)) begin
            next_low_cnt = low_cnt + 4'h1;
        end else begin
            next_qual_rst = 1'b1;
        end
    end

    assign str_cnt_done = (str_cnt == CNT_W'(RST_OUT_CYC - 1));

    always_comb begin
        next_state   = state;
        next_str_cnt = str_cnt;
        case (state)
            RBMS_ST_RESET: begin
                next_str_cnt = '0;
                if (!qual_rst) begin
                    next_state = RBMS_ST_STRETCH;
                end
            end
            RBMS_ST_STRETCH: begin
                if (qual_rst) begin
                    next_state   = RBMS_ST_RESET;
                    next_str_cnt = '0;
                end else if (str_cnt_done) begin
                    next_state = RBMS_ST_RUN;
                end else begin
                    next_str_cnt = str_cnt + CNT_W'(1);
                end
            end
            RBMS_ST_RUN: begin
                if (qual_rst) begin
                    next_state = RBMS_ST_RESET;
                end
            end
            default: begin
                next_state   = RBMS_ST_RESET;
                next_str_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt  <= 4'h0;
            qual_rst <= 1'b1;
            state    <= RBMS_ST_RESET;
            str_cnt  <= '0;
        end else begin
            low_cnt  <= next_low_cnt;
            qual_rst <= next_qual_rst;
            state    <= next_state;
            str_cnt  <= next_str_cnt;
        end
    end

    // Core reset falls the cycle the qualifier fires; reset out covers the stretch too
    assign core_reset_n = !qual_rst && (state != RBMS_ST_RESET);
    assign reset_out_n  = (state == RBMS_ST_RUN);

    // Mode capture: tracks straps while in reset, frozen from release onward
    logic [1:0] mode_sel;
    logic       mode_cry;
    logic       mode_prog;
    logic [1:0] next_mode_sel;
    logic       next_mode_cry;
    logic       next_mode_prog;
    logic [2:0] prediv;
    logic [2:0] next_prediv;
    logic       in_reset;

    assign in_reset = (state == RBMS_ST_RESET);

    always_comb begin
        next_mode_sel  = mode_sel;
        next_mode_cry  = mode_cry;
        next_mode_prog = mode_prog;
        if (in_reset) begin
            next_mode_sel  = sel_q;
            next_mode_cry  = sel_q[0] ? 1'b0 : cry_q;
            next_mode_prog = !req_q && !tst_q;
        end
    end

    // Software may reprogram the pre-divider once out of reset
    always_comb begin
        next_prediv = prediv;
        if (in_reset) begin
            next_prediv = PREDIV_RESET;
        end else if (psel && penable && pwrite && paddr == ADDR_PREDIV) begin
            next_prediv = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_sel  <= 2'h0;
            mode_cry  <= 1'b0;
            mode_prog <= 1'b0;
            prediv    <= PREDIV_RESET;
        end else begin
            mode_sel  <= next_mode_sel;
            mode_cry  <= next_mode_cry;
            mode_prog <= next_mode_prog;
            prediv    <= next_prediv;
        end
    end

    // Decode of the frozen straps
    always_comb begin
        pll_enable         = 1'b0;
        clock_source       = RBMS_SRC_EXT;
        boot_mode_reserved = 1'b0;
        case (mode_sel)
            SEL_BYP_EXT: begin
                clock_source = mode_cry ? RBMS_SRC_OSC : RBMS_SRC_EXT;
            end
            SEL_BYP_CRYSTAL: begin
                clock_source = RBMS_SRC_CRYSTAL;
            end
            SEL_PLL_EXT: begin
                pll_enable         = 1'b1;
                clock_source       = RBMS_SRC_EXT;
                // Reserved strap: PLL stays on external reference, flagged only
                boot_mode_reserved = mode_cry;
            end
            SEL_PLL_CRYSTAL: begin
                pll_enable   = 1'b1;
                clock_source = RBMS_SRC_CRYSTAL;
            end
            default: begin
                pll_enable = 1'b0;
            end
        endcase
    end

    // Pin is an oscillator drive only when the low select bit is set
    assign crystal_drive_pin_oe  = sel_q[0];
    assign crystal_drive_pin_out = 1'b0;

    // Clock gating cells belong in the clock tree; here the clock is forwarded as is
    assign system_clock_out = pclk;

    assign pll_prediv_field        = prediv;
    assign flash_program_mode      = mode_prog && !in_reset;
    assign serial_port_flash_grant = flash_program_mode;

    // APB slave, zero wait states; read data is latched in the setup cycle so that
    // it comes from a flop and stands through the whole access phase
    logic [31:0] rd_word;
    logic [31:0] next_prdata;

    always_comb begin
        rd_word = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            ADDR_STATUS: begin
                rd_word = {23'h0, boot_mode_reserved, flash_program_mode, pll_enable,
                           clock_source, mode_sel, mode_cry, reset_out_n};
            end
            ADDR_PREDIV: begin
                rd_word = {29'h0, prediv};
            end
            default: begin
                pslverr = psel && penable;
            end
        endcase
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end
    assign pready = 1'b1;

    a_reset_qualify: assert property (@(posedge pclk) disable iff (!presetn)
        (!rst_q)[*8] |=> !core_reset_n)
        else $error("core reset not taken after 8 low cycles");

    a_short_glitch: assert property (@(posedge pclk) disable iff (!presetn)
        (state == RBMS_ST_RUN) && !rst_q && low_cnt < 4'(RST_IN_MIN_CYC - 1) |=> reset_out_n)
        else $error("short reset glitch reset the chip");

    sequence s_release;
        $rose(state == RBMS_ST_STRETCH);
    endsequence

    a_stretch_low: assert property (@(posedge pclk) disable iff (!presetn)
        s_release ##0 (!qual_rst)[*8] |-> !reset_out_n)
        else $error("reset out rose during stretch");

    a_stretch_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(reset_out_n) |-> $past(str_cnt) == CNT_W'(RST_OUT_CYC - 1))
        else $error("reset stretch not 1024 cycles");

    a_mode_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        !in_reset && !$past(in_reset) |-> $stable(mode_sel) && $stable(mode_prog))
        else $error("boot mode changed after reset release");

    a_osc_select: assert property (@(posedge pclk) disable iff (!presetn)
        mode_sel == SEL_BYP_EXT && mode_cry |-> clock_source == RBMS_SRC_OSC && !pll_enable)
        else $error("on-chip oscillator mode not decoded");

    a_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
        mode_sel == SEL_BYP_EXT && !mode_cry |-> clock_source == RBMS_SRC_EXT && !pll_enable)
        else $error("external oscillator bypass mode not decoded");

    a_crystal_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        mode_sel == SEL_BYP_CRYSTAL |-> clock_source == RBMS_SRC_CRYSTAL && !pll_enable)
        else $error("crystal bypass mode not decoded");

    a_pin_input: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_q[0] |-> !crystal_drive_pin_oe)
        else $error("crystal pin driven while sampled for mode");

    a_pll_crystal: assert property (@(posedge pclk) disable iff (!presetn)
        mode_sel == SEL_PLL_CRYSTAL |-> pll_enable && clock_source == RBMS_SRC_CRYSTAL)
        else $error("PLL crystal mode not decoded");

    a_prediv_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(in_reset) |-> prediv == PREDIV_RESET)
        else $error("pre-divider not at reset value on release");

    a_prog_grant: assert property (@(posedge pclk) disable iff (!presetn)
        !in_reset |-> serial_port_flash_grant == mode_prog)
        else $error("flash grant without programming mode");
endmodule // rbms_top

// ===== sim/rbms_board.sv
// Board model: reset source, clock mode straps and flash programmer strap
`timescale 1ns/1ps
module rbms_board (
    input  wire logic       pclk,
    input  wire logic       pin_oe,
    input  wire logic       pin_out,
    output logic            reset_in_n,
    output logic [1:0]      sel,
    output logic            pin_level,
    output logic            req_n,
    output logic            test
);
    logic cry;
    // The chip owns the crystal pin while it drives it
    assign pin_level = pin_oe ? pin_out : cry;
    initial begin
        reset_in_n = 1'h1;
        sel = 2'h0;
        cry = 1'h0;
        req_n = 1'h1;
        test = 1'h0;
    end
    // Callers never pick select 10 with the crystal pin high; reference kept under 10 MHz
    task automatic straps(input logic [1:0] s, input logic x, input logic r, input logic t);
        @(posedge pclk);
        sel <= s;
        cry <= x;
        req_n <= r;
        test <= t;
    endtask
    task automatic pulse(input int n);
        @(posedge pclk);
        reset_in_n <= 1'h0;
        repeat (n) @(posedge pclk);
        reset_in_n <= 1'h1;
    endtask
endmodule // rbms_board

// ===== sim/test_reset_and_boot_clock_mode_select.sv
// Self-checking bench for the reset and boot clock mode select block
`timescale 1ns/1ps
module test_reset_and_boot_clock_mode_select;
    import rbms_pkg::*;
    localparam logic [4:0] CASES [6] = '{5'h02, 5'h06, 5'h0e, 5'h10, 5'h19, 5'h08};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ro_q;
    logic        rin_n, pin, req_n, tst, pin_oe, pin_out, clk_out;
    logic        rst_out_n, core_n, pll_en, rsv, fmode, grant;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, st;
    logic [1:0]  sel;
    logic [2:0]  prediv, pv;
    logic [4:0]  c;
    logic [3:0]  md;
    rbms_src_t   src;
    int          fail_count, tests_run, cyc;
    logic [32:0] rdq[$];
    logic [3:0]  modeq[$];

    rbms_top uut (.pclk(pclk), .presetn(presetn), .reset_in_n(rin_n),
        .clock_boot_select(sel), .crystal_drive_pin_in(pin),
        .crystal_drive_pin_out(pin_out), .crystal_drive_pin_oe(pin_oe),
        .flash_program_request_n(req_n), .test_mode(tst), .system_clock_out(clk_out),
        .reset_out_n(rst_out_n), .core_reset_n(core_n), .pll_enable(pll_en),
        .clock_source(src), .pll_prediv_field(prediv), .boot_mode_reserved(rsv),
        .flash_program_mode(fmode), .serial_port_flash_grant(grant), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rbms_board board (.pclk(pclk), .pin_oe(pin_oe), .pin_out(pin_out), .reset_in_n(rin_n),
        .sel(sel), .pin_level(pin), .req_n(req_n), .test(tst));

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // Expected {pll, source, flash mode} from the straps
    function automatic logic [3:0] mode_of(input logic [4:0] k);
        logic [1:0] so;
        so = k[3] ? RBMS_SRC_CRYSTAL : ((k[2] && !k[4]) ? RBMS_SRC_OSC : RBMS_SRC_EXT);
        return {k[4], so, !k[1] && !k[0]};
    endfunction
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'h1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Entry edge keeps psel from being driven twice in one step between transfers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin
            check(1'h0, "apb hang");
            tally_and_finish();
        end
    endtask
    task automatic apb_rd(input logic [11:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (rst_out_n !== 1'h1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000) begin
            check(1'h0, "reset out stuck");
            tally_and_finish();
        end
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin : mon
        logic [32:0] e;
        logic [3:0]  m;
        ro_q <= rst_out_n;
        cyc <= (!rin_n || !presetn || rst_out_n) ? 0 : cyc + 1;
        if (psel && penable && pready && !pwrite) begin
            e = (rdq.size() > 0) ? rdq.pop_front() : 33'h1ffffffff;
            check({pslverr, prdata} === e, "read data");
        end
        if (rst_out_n === 1'h1 && ro_q === 1'h0) begin
            m = (modeq.size() > 0) ? modeq.pop_front() : 4'hf;
            check(cyc >= 1024 && cyc <= 1032, "stretch length");
            check({pll_en, src, fmode} === m, "boot mode");
            check(grant === fmode, "flash grant");
        end
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ro_q = 1'h0;
        cyc = 0;
        fail_count = 0;
        tests_run = 0;
        seed = 32'h4f;
        pv = 3'h0;
        modeq.push_back(mode_of(5'h02));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        wait_run();
        apb_rd(12'h004, 33'h0);
        apb_rd(12'h008, 33'h100000000);
        board.pulse(4);
        repeat (16) @(posedge pclk);
        check(core_n === 1'h1 && rst_out_n === 1'h1, "short pulse reset");
        for (int i = 0; i < 6; i++) begin
            c = CASES[i];
            seed = xs(seed);
            board.straps(c[4:3], c[2], c[1], c[0]);
            modeq.push_back(mode_of(c));
            fork
                board.pulse(30);
                begin
                    repeat (18) @(posedge pclk);
                    check(core_n === 1'h0 && rst_out_n === 1'h0, "long pulse");
                    check(pin_oe === c[3], "crystal pin dir");
                    apb(1'h1, 12'h004, seed);
                end
            join
            wait_run();
            apb_rd(12'h004, {30'h0, PREDIV_RESET});
            md = mode_of(c);
            st = {23'h0, 1'h0, md[0], md[3], md[2:1], c[4:3], c[2] && !c[3], 1'h1};
            apb_rd(12'h000, {1'h0, st});
            pv = seed[2:0];
            apb(1'h1, 12'h004, seed);
            apb_rd(12'h004, {30'h0, pv});
            // Inverted straps after release; select 10 keeps the crystal pin low
            board.straps(~c[4:3], !c[3] && !c[2], ~c[1], ~c[0]);
            apb(1'h1, 12'h000, seed);
            apb_rd(12'h000, {1'h0, st});
            #2 check(clk_out === pclk, "clock out");
        end
        tally_and_finish();
    end
endmodule // test_reset_and_boot_clock_mode_select
